// ### rtl/crl_chan.sv
`timescale 1ns/1ns
module crl_chan
  import crl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire crl_cmd_s cmd_i,
  input wire crl_ce_s ce_i,
  output logic [7:0] rd_byte_o,
  output logic [MODE_W-1:0] mode_o,
  output logic null_o,
  output logic cnt_lat_o,
  output logic sts_lat_o,
  output logic wr_hi_o,
  output logic [CNT_W-1:0] cnt_hold_o,
  output logic [7:0] sts_hold_o
);

  // ---------------------------------------------------------------
  // Per-counter state
  // ---------------------------------------------------------------
  logic [MODE_W-1:0] mode_r;
  logic null_r, null_nxt, cnt_lat_r, sts_lat_r, rd_hi_r, wr_hi_r;
  logic [CNT_W-1:0] cnt_hold_r;
  logic [7:0] sts_hold_r;
  wire fmt_word = (mode_r[FMT_LSB_POS+:2] == FMT_WORD);
  wire fmt_msb = (mode_r[FMT_LSB_POS+:2] == FMT_MSB_ONLY);
  wire [CNT_W-1:0] cnt_src = cnt_lat_r ? cnt_hold_r : ce_i.count;
  wire hi_sel = fmt_word ? rd_hi_r : fmt_msb;
  wire cnt_done = !fmt_word || rd_hi_r;
  wire null_set = cmd_i.ctrl_wr || (cmd_i.cnt_wr && (!fmt_word || wr_hi_r));

  // status goes out ahead of any frozen count.
  assign rd_byte_o = sts_lat_r ? sts_hold_r :
                     (hi_sel ? cnt_src[15:8] : cnt_src[7:0]);
  assign mode_o = mode_r;
  assign null_o = null_r;
  assign cnt_lat_o = cnt_lat_r;
  assign sts_lat_o = sts_lat_r;
  assign wr_hi_o = wr_hi_r;
  assign cnt_hold_o = cnt_hold_r;
  assign sts_hold_o = sts_hold_r;

  // set and clear. A flag-setting write wins over a load in the same cycle.
  assign null_nxt = null_set ? 1'b1 : (ce_i.ce_load ? 1'b0 : null_r);

  // Mode and null flag.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= MODE_RST;
      null_r <= NULL_RST;
    end else begin
      null_r <= null_nxt;
      if (cmd_i.ctrl_wr) begin
        mode_r <= cmd_i.mode;
      end
    end
  end

  // count freeze until read; source is the element.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_lat_r <= 1'b0;
      cnt_hold_r <= '0;
    end else if (cmd_i.ctrl_wr) begin
      cnt_lat_r <= 1'b0;
    end else if (cmd_i.rb_count && !cnt_lat_r) begin
      cnt_lat_r <= 1'b1;
      cnt_hold_r <= ce_i.count;
    end else if (cmd_i.rd && !sts_lat_r && cnt_done) begin
      cnt_lat_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sts_lat_r <= 1'b0;
      sts_hold_r <= 8'h00;
    end else if (cmd_i.ctrl_wr) begin
      sts_lat_r <= 1'b0;
    end else if (cmd_i.rb_status && !sts_lat_r) begin
      sts_lat_r <= 1'b1;
      sts_hold_r <= {ce_i.out_level, null_r, mode_r};
    end else if (cmd_i.rd) begin
      sts_lat_r <= 1'b0;
    end
  end

  // byte order of two-byte reads and writes.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_hi_r <= 1'b0;
      wr_hi_r <= 1'b0;
    end else if (cmd_i.ctrl_wr) begin
      rd_hi_r <= 1'b0;
      wr_hi_r <= 1'b0;
    end else begin
      if (cmd_i.rd && !sts_lat_r && fmt_word) begin
        rd_hi_r <= !rd_hi_r;
      end
      if (cmd_i.cnt_wr && fmt_word) begin
        wr_hi_r <= !wr_hi_r;
      end
    end
  end

endmodule

// ### rtl/crl_pkg.sv
package crl_pkg;

  // ---------------------------------------------------------------
  // Sizes and port decode
  // ---------------------------------------------------------------
  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;
  localparam int MODE_W = 6;
  localparam logic [1:0] ADDR_CTRL = 2'h3;

  // ---------------------------------------------------------------
  // Command word fields
  // ---------------------------------------------------------------
  localparam int CW_SC_LSB = 6;
  localparam logic [1:0] CW_READBACK = 2'h3;
  localparam logic [1:0] CW_LATCH_CMD = 2'h0;
  localparam int RB_CNT_N_BIT = 5;
  localparam int RB_STS_N_BIT = 4;
  localparam int RB_SEL_LSB = 1;
  localparam int RB_ZERO_BIT = 0;

  // ---------------------------------------------------------------
  // Mode and status fields, reset values
  // ---------------------------------------------------------------
  localparam int FMT_LSB_POS = 4;
  localparam logic [1:0] FMT_MSB_ONLY = 2'h2;
  localparam logic [1:0] FMT_WORD = 2'h3;
  localparam int STS_OUT_BIT = 7;
  localparam int STS_NULL_BIT = 6;
  localparam logic [MODE_W-1:0] MODE_RST = 6'h00;
  localparam logic NULL_RST = 1'b1;

  // Host access decoded from the strobes.
  typedef enum logic [1:0] {
    ACC_NONE = 2'b00,
    ACC_RD = 2'b01,
    ACC_WR = 2'b10
  } crl_acc_e;

  // Live state of one counting element.
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic out_level;
    logic ce_load;
  } crl_ce_s;

  // One-cycle commands to one channel.
  typedef struct packed {
    logic ctrl_wr;
    logic [MODE_W-1:0] mode;
    logic rb_count;
    logic rb_status;
    logic cnt_wr;
    logic rd;
  } crl_cmd_s;

endpackage

// ### rtl/crl_readback.sv
`timescale 1ns/1ns
// Function
// - A read-back with the count bit low freezes each selected count.
// - A frozen count holds until that counter is read or reprogrammed.
// - Further count captures on a frozen counter are ignored.
// - A read-back with the status bit low captures each selected status.
// - Status is out level, null flag, then the six mode bits.
// - Null flag is set by a control or count write, cleared on load.
// - A control word sets the null flag of its own counter only.
// - In two-byte format the null flag is set on the second byte.
// - Counts are taken from the counting element, not the load register.
// - Further status captures on a captured counter are ignored.
// - Both bits low capture both parts, each first capture wins.
// - With both captured, status reads first, then the frozen count.
// - Port decode selects counters 0-2 and control, else no operation.
// - Read-back is top bits 11, bits 3-1 select counters, bit 0 is 0.
module crl_readback
  import crl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_sel_hi_i,
  input wire logic port_sel_lo_i,
  input wire logic [7:0] data_i,
  input wire crl_ce_s [NUM_CH-1:0] ce_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  output logic [NUM_CH-1:0] null_count_o,
  output logic [NUM_CH-1:0][MODE_W-1:0] mode_o
);

  // ---------------------------------------------------------------
  // Strobe sampling
  // ---------------------------------------------------------------
  logic rd_n_q_r, wr_n_q_r;
  logic [7:0] data_r, data_nxt;
  logic data_oe_n_r, data_oe_n_nxt;
  crl_acc_e acc;

  // Previous strobe levels, so each strobe acts on its leading edge.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_n_q_r <= 1'b1;
      wr_n_q_r <= 1'b1;
    end else begin
      rd_n_q_r <= rd_n_i;
      wr_n_q_r <= wr_n_i;
    end
  end

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  wire [1:0] port_sel = {port_sel_hi_i, port_sel_lo_i};
  wire is_ctrl = (port_sel == ADDR_CTRL);
  // only a counter port may be read.
  wire rd_level = !cs_n_i && !rd_n_i && wr_n_i && !is_ctrl;
  wire wr_level = !cs_n_i && !wr_n_i && rd_n_i;
  wire rd_pulse = rd_level && rd_n_q_r;
  wire wr_pulse = wr_level && wr_n_q_r;
  assign acc = rd_pulse ? ACC_RD : (wr_pulse ? ACC_WR : ACC_NONE);

  // Command word classes.
  wire ctrl_wr = (acc == ACC_WR) && is_ctrl;
  wire [1:0] cw_sc = data_i[CW_SC_LSB+:2];
  // read-back needs top bits 11 and bit 0 clear.
  wire rb_cmd = ctrl_wr && (cw_sc == CW_READBACK) && !data_i[RB_ZERO_BIT];
  wire mode_cmd = ctrl_wr && (cw_sc != CW_READBACK) &&
                  (data_i[RB_STS_N_BIT+:2] != CW_LATCH_CMD);

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  crl_cmd_s [NUM_CH-1:0] cmd;
  logic [NUM_CH-1:0][7:0] rd_byte, sts_hold;
  logic [NUM_CH-1:0][CNT_W-1:0] cnt_hold;
  logic [NUM_CH-1:0] null_w, cnt_lat, sts_lat, wr_hi;
  logic [NUM_CH-1:0][MODE_W-1:0] mode_w;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
      // a control word reaches only the counter it names.
      assign cmd[gi].ctrl_wr = mode_cmd && (cw_sc == 2'(gi));
      assign cmd[gi].mode = data_i[MODE_W-1:0];
      // each selected counter takes each enabled part.
      assign cmd[gi].rb_count = rb_cmd && data_i[RB_SEL_LSB+gi] &&
                                !data_i[RB_CNT_N_BIT];
      assign cmd[gi].rb_status = rb_cmd && data_i[RB_SEL_LSB+gi] &&
                                 !data_i[RB_STS_N_BIT];
      // counter ports load counts and return data.
      assign cmd[gi].cnt_wr = (acc == ACC_WR) && (port_sel == 2'(gi));
      assign cmd[gi].rd = (acc == ACC_RD) && (port_sel == 2'(gi));

      crl_chan u_chan (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .cmd_i(cmd[gi]),
        .ce_i(ce_i[gi]),
        .rd_byte_o(rd_byte[gi]),
        .mode_o(mode_w[gi]),
        .null_o(null_w[gi]),
        .cnt_lat_o(cnt_lat[gi]),
        .sts_lat_o(sts_lat[gi]),
        .wr_hi_o(wr_hi[gi]),
        .cnt_hold_o(cnt_hold[gi]),
        .sts_hold_o(sts_hold[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  // the byte is taken once, at the leading edge of the read.
  assign data_nxt = rd_pulse ? rd_byte[port_sel] : data_r;
  // the bus is driven only during a valid counter read.
  assign data_oe_n_nxt = !rd_level;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_r <= 8'h00;
      data_oe_n_r <= 1'b1;
    end else begin
      data_r <= data_nxt;
      data_oe_n_r <= data_oe_n_nxt;
    end
  end

  assign data_o = data_r;
  assign data_oe_n_o = data_oe_n_r;
  assign null_count_o = null_w;
  assign mode_o = mode_w;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // A counter holding both parts is read once.
  sequence seq_both_read(int c);
    sts_lat[c] && cnt_lat[c] && cmd[c].rd;
  endsequence

  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_chk
      chk_count_freeze: assert property (
        cmd[gi].rb_count && !cnt_lat[gi] && !cmd[gi].ctrl_wr |=>
        cnt_lat[gi] && cnt_hold[gi] == $past(ce_i[gi].count))
      else $error("count not frozen on read-back");

      chk_count_hold: assert property (
        cnt_lat[gi] && !cmd[gi].rd && !cmd[gi].ctrl_wr |=>
        cnt_lat[gi] && $stable(cnt_hold[gi]))
      else $error("frozen count released without read");

      chk_count_first: assert property (
        cnt_lat[gi] && cmd[gi].rb_count |=> $stable(cnt_hold[gi]))
      else $error("second count capture overwrote hold");

      chk_status_fmt: assert property (
        cmd[gi].rb_status && !sts_lat[gi] && !cmd[gi].ctrl_wr |=>
        sts_lat[gi] && sts_hold[gi] == {$past(ce_i[gi].out_level),
        $past(null_w[gi]), $past(mode_w[gi])})
      else $error("status byte wrong after capture");

      chk_status_first: assert property (
        sts_lat[gi] && cmd[gi].rb_status |=> $stable(sts_hold[gi]))
      else $error("second status capture overwrote hold");

      chk_null_set: assert property (
        cmd[gi].ctrl_wr |=> null_w[gi])
      else $error("null flag not set by control word");

      chk_null_clear: assert property (
        ce_i[gi].ce_load && !cmd[gi].ctrl_wr && !cmd[gi].cnt_wr |=>
        !null_w[gi])
      else $error("null flag not cleared on load");

      chk_null_other: assert property (
        mode_cmd && !cmd[gi].ctrl_wr && !cmd[gi].cnt_wr &&
        !ce_i[gi].ce_load |=> null_w[gi] == $past(null_w[gi]))
      else $error("control word touched another null flag");

      chk_null_word: assert property (
        cmd[gi].cnt_wr && !wr_hi[gi] && !null_w[gi] &&
        mode_w[gi][FMT_LSB_POS+:2] == FMT_WORD && !ce_i[gi].ce_load
        |=> !null_w[gi] && wr_hi[gi])
      else $error("null flag set on first byte");

      chk_status_take: assert property (
        cmd[gi].rb_status |=> sts_lat[gi])
      else $error("status not captured on read-back");

      chk_status_order: assert property (
        seq_both_read(gi) |=>
        data_o == $past(sts_hold[gi]) && !sts_lat[gi] && cnt_lat[gi])
      else $error("status not returned first");
    end
  endgenerate

  chk_noop_float: assert property (
    cs_n_i || (rd_n_i && wr_n_i) || (is_ctrl && !rd_n_i) |=>
    data_oe_n_o)
  else $error("bus driven during no-operation");

  chk_strobe_once: assert property (
    rd_pulse ##1 !rd_n_i && !cs_n_i |-> !rd_pulse)
  else $error("held read strobe acted twice");

  chk_rb_zero_bit: assert property (
    ctrl_wr && cw_sc == CW_READBACK && data_i[RB_ZERO_BIT] |=>
    $stable(cnt_lat) && $stable(sts_lat))
  else $error("read-back with bit 0 set took effect");

  chk_noop_write: assert property (
    cs_n_i |=> $stable(mode_w) && $stable(cnt_lat) && $stable(sts_lat))
  else $error("access acted with chip select high");

  chk_data_stands: assert property (
    !rd_pulse |=> $stable(data_o))
  else $error("read byte changed without a read");

endmodule

// ### tb/crl_host.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host processor model on the parallel port
// ---------------------------------------------------------------
module crl_host (
  input wire logic sys_clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic oe_n_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [1:0] sel_o,
  output logic [7:0] dat_o
);
  // Strobes start high so the first access has a clean leading edge.
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sel_o = 2'h0;
    dat_o = 8'h00;
  end

  // port access cycle.
  // One access: the strobe stays low for hold edges, then rises for one
  // edge so that back to back accesses each show a fresh leading edge.
  // Released data is inverted so a stale byte is never mistaken.
  // The answer is taken at the last edge with the strobe low, because the
  // output enable follows the strobe and is gone one edge after release.
  task automatic acc(input logic w, input logic cs, input logic [1:0] a,
                     input logic [7:0] d, input int hold,
                     output logic [7:0] q, output logic oe);
    @(posedge sys_clk_i);
    cs_n_o <= cs;
    sel_o <= a;
    dat_o <= d;
    if (w) begin
      wr_n_o <= 1'b0;
    end else begin
      rd_n_o <= 1'b0;
    end
    repeat (hold) @(posedge sys_clk_i);
    q = rd_data_i;
    oe = oe_n_i;
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    dat_o <= ~d;
    @(posedge sys_clk_i);
    #1;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import crl_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cs_n, rd_n, wr_n, oe_n, o;
  logic [1:0] sel;
  logic [7:0] din, dout, q;
  crl_ce_s [NUM_CH-1:0] ce;
  logic [NUM_CH-1:0] nullc;
  logic [NUM_CH-1:0][MODE_W-1:0] mode;
  int err_total = 0;
  int compares = 0;

  // ---------------------------------------------------------------
  // Clock, device and host
  // ---------------------------------------------------------------
  always #4 sys_clk_i = ~sys_clk_i;

  crl_readback dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .port_sel_hi_i(sel[1]),
    .port_sel_lo_i(sel[0]), .data_i(din), .ce_i(ce), .data_o(dout),
    .data_oe_n_o(oe_n), .null_count_o(nullc), .mode_o(mode));

  crl_host host (.sys_clk_i(sys_clk_i), .rd_data_i(dout), .oe_n_i(oe_n),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .sel_o(sel),
    .dat_o(din));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    host.acc(1'b1, 1'b0, a, d, 1, q, o);
  endtask

  // A counter read must drive the bus and return the expected byte.
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    host.acc(1'b0, 1'b0, a, 8'h00, 2, q, o);
    chk(18'({o, q}), 18'({1'b0, e}));
  endtask

  // The counting element pulses its load flag for one cycle.
  task automatic load(input logic [2:0] m);
    @(posedge sys_clk_i);
    for (int i = 0; i < NUM_CH; i++) ce[i].ce_load <= m[i];
    @(posedge sys_clk_i);
    for (int i = 0; i < NUM_CH; i++) ce[i].ce_load <= 1'b0;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic setc(input int i, input logic [15:0] v, input logic ov);
    @(posedge sys_clk_i);
    ce[i].count <= v;
    ce[i].out_level <= ov;
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    err_total++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    ce = '0;
    ce[0].count = 16'h1234;
    ce[1].count = 16'h5678;
    ce[2].count = 16'h9ABC;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(18'(nullc), 18'h7);
    chk(18'(oe_n), 18'h1);
    $display("test reset done");
    wr(2'h3, 8'h34);
    wr(2'h3, 8'h74);
    wr(2'h3, 8'hB4);
    chk(18'(mode), {6'h34, 6'h34, 6'h34});
    load(3'h7);
    chk(18'(nullc), 18'h0);
    wr(2'h3, 8'h74);
    chk(18'(nullc), 18'h2);
    load(3'h2);
    wr(2'h0, 8'hCD);
    chk(18'(nullc), 18'h0);
    wr(2'h0, 8'hAB);
    chk(18'(nullc), 18'h1);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    load(3'h1);
    $display("test null flag done");
    wr(2'h3, 8'hDA);
    setc(0, 16'h1157, 1'b0);
    setc(2, 16'h2222, 1'b0);
    wr(2'h3, 8'hD2);
    rd(2'h2, 8'hBC);
    rd(2'h2, 8'h9A);
    rd(2'h0, 8'h34);
    rd(2'h0, 8'h12);
    rd(2'h0, 8'h57);
    rd(2'h0, 8'h11);
    $display("test count freeze done");
    setc(1, 16'h5678, 1'b1);
    wr(2'h3, 8'hC4);
    setc(1, 16'h0F0F, 1'b0);
    wr(2'h3, 8'hE4);
    wr(2'h3, 8'hD4);
    rd(2'h1, 8'hB4);
    rd(2'h1, 8'h78);
    rd(2'h1, 8'h56);
    rd(2'h1, 8'h0F);
    $display("test status done");
    host.acc(1'b0, 1'b0, 2'h3, 8'h00, 2, q, o);
    chk(18'(o), 18'h1);
    host.acc(1'b1, 1'b1, 2'h3, 8'h10, 1, q, o);
    chk(18'(mode[0]), 18'h34);
    wr(2'h3, 8'hC3);
    rd(2'h0, 8'h57);
    rd(2'h0, 8'h11);
    wr(2'h3, 8'hD2);
    setc(0, 16'h3333, 1'b0);
    host.acc(1'b0, 1'b0, 2'h0, 8'h00, 4, q, o);
    chk(18'({o, q}), 18'h057);
    rd(2'h0, 8'h11);
    rd(2'h0, 8'h33);
    $display("test decode done");
    end_of_test();
  end
endmodule
